// File: bdd_branch_display_decode.sv
// Branch and display on/off decode and execute stage of the 4-bit core
//
// Notes on behaviour
// - Bit-2 jump branches when accumulator bit 2 is one, else falls through.
// - Bit-3 jump branches when accumulator bit 3 is one, else falls through.
// - Carry-set jump branches when carry is one, falls through when zero.
// - Nonzero jump branches when accumulator is not zero.
// - Zero jump branches when accumulator is zero.
// - Absolute branch always loads the target, testing nothing.
// - False condition only increments the counter; accumulator and flags untouched.
// - Taken jump replaces counter bits 10..0 with word bits 10..0.
// - Display-off word disables the display drive, blanking it.
`timescale 1ns/10ps
`default_nettype none
module bdd_branch_display_decode (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Fetch path: one word per machine cycle when valid
   input wire logic [bdd_pkg::WORD_W-1:0] instr_word,
   input wire logic instr_valid,
   // Core state tested by conditions
   input wire bdd_pkg::bdd_cond_s cond,
   // Program counter and status
   output logic [bdd_pkg::PC_W-1:0] prog_counter,
   output logic branch_taken,
   output logic instr_done,
   output logic handled,
   // Display drive enable
   output logic display_drive_en
);
   bdd_pkg::bdd_dec_s dec;
   logic take;
   logic [bdd_pkg::PC_W-1:0] next_prog_counter;
   logic next_branch_taken;
   logic next_instr_done;
   logic next_handled;
   logic next_display_drive_en;

   // Opcode map for the fetched word
   bdd_opmap i_bdd_opmap (
      .word(instr_word),
      .dec(dec)
   );

   // Branch condition; display and foreign words never jump
   always_comb begin
      unique case (dec.op)
         bdd_pkg::BDD_OP_BIT2: take = cond.work_accumulator[2];
         bdd_pkg::BDD_OP_BIT3: take = cond.work_accumulator[3];
         bdd_pkg::BDD_OP_CSET: take = cond.carry_flag;
         bdd_pkg::BDD_OP_CCLR: take = ~cond.carry_flag;
         bdd_pkg::BDD_OP_NZ: take = |cond.work_accumulator;
         bdd_pkg::BDD_OP_Z: take = ~|cond.work_accumulator;
         bdd_pkg::BDD_OP_ABS: take = 1'b1;
         default: take = 1'b0;
      endcase
   end

   // Next counter, pulses and display drive for the presented word
   always_comb begin
      next_prog_counter = prog_counter;
      next_branch_taken = 1'b0;
      next_instr_done = 1'b0;
      next_handled = 1'b0;
      next_display_drive_en = display_drive_en;
      if (instr_valid) begin
         // Each word retires in the cycle after it is presented
         next_instr_done = 1'b1;
         next_handled = (dec.op != bdd_pkg::BDD_OP_NONE);
         if (take) begin
            next_prog_counter = dec.target;
            next_branch_taken = 1'b1;
         end else begin
            next_prog_counter = prog_counter + {{(bdd_pkg::PC_W-1){1'b0}}, 1'b1};
         end
         if (dec.op == bdd_pkg::BDD_OP_DON) begin
            next_display_drive_en = 1'b1;
         end else if (dec.op == bdd_pkg::BDD_OP_DOFF) begin
            next_display_drive_en = 1'b0;
         end
      end
   end

   // Registered outputs; a held reset parks the counter and blanks the display
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prog_counter <= bdd_pkg::PC_RESET;
         branch_taken <= 1'b0;
         instr_done <= 1'b0;
         handled <= 1'b0;
         display_drive_en <= bdd_pkg::DISP_RESET;
      end else begin
         prog_counter <= next_prog_counter;
         branch_taken <= next_branch_taken;
         instr_done <= next_instr_done;
         handled <= next_handled;
         display_drive_en <= next_display_drive_en;
      end
   end

   // Condition decisions, judged one cycle after the word is taken
   AST_BIT2: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op == bdd_pkg::BDD_OP_BIT2 |=> branch_taken == $past(cond.work_accumulator[2]))
      else $error("bit-2 jump decision wrong");

   AST_BIT3: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op == bdd_pkg::BDD_OP_BIT3 |=> branch_taken == $past(cond.work_accumulator[3]))
      else $error("bit-3 jump decision wrong");

   AST_CSET: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op == bdd_pkg::BDD_OP_CSET |=> branch_taken == $past(cond.carry_flag))
      else $error("carry-set jump decision wrong");

   AST_CCLR: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op == bdd_pkg::BDD_OP_CCLR |=> branch_taken != $past(cond.carry_flag))
      else $error("carry-clear jump decision wrong");

   AST_NZ: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op == bdd_pkg::BDD_OP_NZ |=> branch_taken == ($past(cond.work_accumulator) != 4'h0))
      else $error("nonzero jump decision wrong");

   AST_Z: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op == bdd_pkg::BDD_OP_Z |=> branch_taken == ($past(cond.work_accumulator) == 4'h0))
      else $error("zero jump decision wrong");

   AST_ABS: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_ABSOLUTE_BRANCH
      |=> branch_taken && prog_counter == $past(instr_word[bdd_pkg::PC_W-1:0]))
      else $error("absolute branch not taken");

   // Counter update on fall-through and on a taken jump
   AST_FALL: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && !take |=> !branch_taken && prog_counter == 11'($past(prog_counter) + 11'h001))
      else $error("fall-through did not increment");

   AST_TARGET: assert property (@(posedge ref_clk) disable iff (rst)
      branch_taken |-> prog_counter == $past(instr_word[10:0]))
      else $error("taken jump target wrong");

   AST_TAKEN: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && take |=> branch_taken && prog_counter == $past(dec.target))
      else $error("taken jump not loaded");

   // Display drive moves only on its own two words
   AST_DON: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && instr_word == 16'h0400 |=> display_drive_en)
      else $error("display not enabled");

   AST_DOFF: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && instr_word == 16'h0500 |=> !display_drive_en)
      else $error("display not blanked");

   AST_DISP_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      !(instr_valid && (dec.op == bdd_pkg::BDD_OP_DON || dec.op == bdd_pkg::BDD_OP_DOFF))
      |=> display_drive_en == $past(display_drive_en))
      else $error("display drive moved without its word");

   AST_DISP_NOJUMP: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && (dec.op == bdd_pkg::BDD_OP_DON || dec.op == bdd_pkg::BDD_OP_DOFF) |-> !take)
      else $error("display word would branch");

   // Retirement pulses
   AST_ONECYC: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid |=> instr_done)
      else $error("instruction not done in one cycle");

   AST_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
      !instr_valid |=> !instr_done && !branch_taken && !handled && prog_counter == $past(prog_counter))
      else $error("state moved without a word");

   AST_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
      branch_taken || handled |-> instr_done)
      else $error("status pulse without retirement");

   // Opcode map keeps every word distinct
   AST_DISTINCT: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && (instr_word == 16'h0400 || instr_word == 16'h0500) |=> !branch_taken && handled)
      else $error("display word aliased a jump");

   AST_NONE: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op == bdd_pkg::BDD_OP_NONE |=> instr_done && !handled && !branch_taken)
      else $error("foreign word flagged as handled");

   AST_KNOWN: assert property (@(posedge ref_clk) disable iff (rst)
      instr_valid && dec.op != bdd_pkg::BDD_OP_NONE |=> handled)
      else $error("block word not flagged as handled");

   AST_MAP_BIT2: assert property (@(posedge ref_clk) disable iff (rst)
      instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_JUMP_IF_ACC_BIT2
      |-> dec.op == bdd_pkg::BDD_OP_BIT2)
      else $error("bit-2 jump code misdecoded");

   AST_MAP_BIT3: assert property (@(posedge ref_clk) disable iff (rst)
      instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_JUMP_IF_ACC_BIT3
      |-> dec.op == bdd_pkg::BDD_OP_BIT3)
      else $error("bit-3 jump code misdecoded");

   AST_MAP_CSET: assert property (@(posedge ref_clk) disable iff (rst)
      instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_JUMP_IF_CARRY_SET
      |-> dec.op == bdd_pkg::BDD_OP_CSET)
      else $error("carry-set jump code misdecoded");

   AST_MAP_CCLR: assert property (@(posedge ref_clk) disable iff (rst)
      instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_JUMP_IF_CARRY_CLEAR
      |-> dec.op == bdd_pkg::BDD_OP_CCLR)
      else $error("carry-clear jump code misdecoded");

   AST_MAP_NZ: assert property (@(posedge ref_clk) disable iff (rst)
      instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_JUMP_IF_NONZERO
      |-> dec.op == bdd_pkg::BDD_OP_NZ)
      else $error("nonzero jump code misdecoded");

   AST_MAP_Z: assert property (@(posedge ref_clk) disable iff (rst)
      instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_JUMP_IF_ZERO
      |-> dec.op == bdd_pkg::BDD_OP_Z)
      else $error("zero jump code misdecoded");

   AST_MAP_ABS: assert property (@(posedge ref_clk) disable iff (rst)
      instr_word[bdd_pkg::OP_HI:bdd_pkg::OP_LO] == bdd_pkg::OP_ABSOLUTE_BRANCH
      |-> dec.op == bdd_pkg::BDD_OP_ABS)
      else $error("absolute branch code misdecoded");
endmodule // bdd_branch_display_decode
`default_nettype wire

// File: bdd_branch_display_decode_tb_top.sv
// Self-checking testbench for the branch and display instruction decoder
`timescale 1ns/10ps
`default_nettype none
module bdd_branch_display_decode_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] instr_word = 16'h0000;
   logic instr_valid = 1'b0;
   bdd_pkg::bdd_cond_s cond = '0;
   logic [10:0] prog_counter;
   logic branch_taken, instr_done, handled, display_drive_en;
   logic [10:0] pc_exp = 11'h000;
   logic disp_exp = 1'b0;
   int checks = 0;
   int failures = 0;

   always #4 ref_clk = ~ref_clk;

   bdd_branch_display_decode i_bdd_branch_display_decode (
      .ref_clk(ref_clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid), .cond(cond),
      .prog_counter(prog_counter), .branch_taken(branch_taken), .instr_done(instr_done),
      .handled(handled), .display_drive_en(display_drive_en));

   task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // One instruction per call, judged one cycle later
   task automatic step(input logic [15:0] w, input logic [3:0] accum, input logic cf, input logic tk, input logic hd);
      instr_valid = 1'b1;
      instr_word = w;
      cond.work_accumulator = accum;
      cond.carry_flag = cf;
      pc_exp = tk ? w[10:0] : pc_exp + 11'h001;
      if (w === bdd_pkg::OP_DISPLAY_DRIVE_ON) disp_exp = 1'b1;
      else if (w === bdd_pkg::OP_DISPLAY_DRIVE_OFF) disp_exp = 1'b0;
      @(negedge ref_clk);
      chk(prog_counter, pc_exp, "program counter");
      chk(11'(branch_taken), 11'(tk), "branch taken");
      chk(11'(instr_done), 11'h001, "done pulse");
      chk(11'(handled), 11'(hd), "handled");
      chk(11'(display_drive_en), 11'(disp_exp), "display drive");
   endtask

   task automatic t_bits;
      step({bdd_pkg::OP_JUMP_IF_ACC_BIT2, 11'h155}, 4'h4, 1'b0, 1'b1, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_ACC_BIT2, 11'h2aa}, 4'hb, 1'b1, 1'b0, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_ACC_BIT3, 11'h3c3}, 4'h8, 1'b0, 1'b1, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_ACC_BIT3, 11'h001}, 4'h7, 1'b1, 1'b0, 1'b1);
   endtask

   task automatic t_carry;
      step({bdd_pkg::OP_JUMP_IF_CARRY_SET, 11'h456}, 4'h0, 1'b1, 1'b1, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_CARRY_SET, 11'h0f0}, 4'hf, 1'b0, 1'b0, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_CARRY_CLEAR, 11'h60f}, 4'hf, 1'b0, 1'b1, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_CARRY_CLEAR, 11'h111}, 4'h0, 1'b1, 1'b0, 1'b1);
   endtask

   task automatic t_accum;
      step({bdd_pkg::OP_JUMP_IF_NONZERO, 11'h222}, 4'h1, 1'b0, 1'b1, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_NONZERO, 11'h333}, 4'h8, 1'b0, 1'b1, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_NONZERO, 11'h444}, 4'h0, 1'b1, 1'b0, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_ZERO, 11'h5a5}, 4'h0, 1'b1, 1'b1, 1'b1);
      step({bdd_pkg::OP_JUMP_IF_ZERO, 11'h066}, 4'h2, 1'b0, 1'b0, 1'b1);
   endtask

   task automatic t_abs;
      step({bdd_pkg::OP_ABSOLUTE_BRANCH, 11'h7ff}, 4'h0, 1'b0, 1'b1, 1'b1);
      step(16'h0001, 4'h0, 1'b0, 1'b0, 1'b0);
      step({bdd_pkg::OP_ABSOLUTE_BRANCH, 11'h000}, 4'hf, 1'b1, 1'b1, 1'b1);
   endtask

   task automatic t_disp;
      step(bdd_pkg::OP_DISPLAY_DRIVE_ON, 4'h0, 1'b0, 1'b0, 1'b1);
      step(16'h0401, 4'h0, 1'b0, 1'b0, 1'b0);
      step(bdd_pkg::OP_DISPLAY_DRIVE_OFF, 4'hf, 1'b1, 1'b0, 1'b1);
      step(16'h0501, 4'h0, 1'b0, 1'b0, 1'b0);
      step(bdd_pkg::OP_DISPLAY_DRIVE_ON, 4'h0, 1'b0, 1'b0, 1'b1);
      step({bdd_pkg::OP_ABSOLUTE_BRANCH, 11'h0a5}, 4'h0, 1'b0, 1'b1, 1'b1);
   endtask

   task automatic t_idle;
      instr_valid = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(11'(instr_done), 11'h000, "idle done");
      chk(prog_counter, pc_exp, "idle counter");
   endtask

   // Reset in mid-run with the display drive on
   task automatic t_reset;
      instr_valid = 1'b0;
      rst = 1'b1;
      @(negedge ref_clk);
      chk(prog_counter, 11'h000, "reset counter");
      chk(11'(display_drive_en), 11'h000, "reset display");
      rst = 1'b0;
      pc_exp = 11'h000;
      disp_exp = 1'b0;
      @(negedge ref_clk);
   endtask

   initial begin
      #100000;
      failures++;
      finish_test();
   end

   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      chk(prog_counter, 11'h000, "counter after reset");
      t_bits();
      t_carry();
      t_accum();
      t_abs();
      t_disp();
      t_idle();
      t_reset();
      t_bits();
      t_idle();
      finish_test();
   end
endmodule // bdd_branch_display_decode_tb_top
`default_nettype wire

// File: bdd_opmap.sv
// Combinational opcode map for the branch and display instructions
`timescale 1ns/10ps
`default_nettype none
module bdd_opmap (
   // Fetched word
   input wire logic [bdd_pkg::WORD_W-1:0] word,
   // Decoded operation
   output var bdd_pkg::bdd_dec_s dec
);
   logic [4:0] major;

   assign major = word[bdd_pkg::OP_HI:bdd_pkg::OP_LO];

   always_comb begin
      dec.target = word[bdd_pkg::PC_W-1:0];
      dec.op = bdd_pkg::BDD_OP_NONE;
      // Display words are matched whole so they never alias a jump
      if (word == bdd_pkg::OP_DISPLAY_DRIVE_ON) begin
         dec.op = bdd_pkg::BDD_OP_DON;
      end else if (word == bdd_pkg::OP_DISPLAY_DRIVE_OFF) begin
         dec.op = bdd_pkg::BDD_OP_DOFF;
      end else begin
         unique case (major)
            bdd_pkg::OP_JUMP_IF_ACC_BIT2: dec.op = bdd_pkg::BDD_OP_BIT2;
            bdd_pkg::OP_JUMP_IF_ACC_BIT3: dec.op = bdd_pkg::BDD_OP_BIT3;
            bdd_pkg::OP_JUMP_IF_CARRY_SET: dec.op = bdd_pkg::BDD_OP_CSET;
            bdd_pkg::OP_JUMP_IF_CARRY_CLEAR: dec.op = bdd_pkg::BDD_OP_CCLR;
            bdd_pkg::OP_JUMP_IF_NONZERO: dec.op = bdd_pkg::BDD_OP_NZ;
            bdd_pkg::OP_JUMP_IF_ZERO: dec.op = bdd_pkg::BDD_OP_Z;
            bdd_pkg::OP_ABSOLUTE_BRANCH: dec.op = bdd_pkg::BDD_OP_ABS;
            default: dec.op = bdd_pkg::BDD_OP_NONE;
         endcase
      end
   end
endmodule // bdd_opmap
`default_nettype wire

// File: bdd_pkg.sv
// Package for the branch and display instruction decoder: opcode map, field layout, reset values
package bdd_pkg;
   localparam int PC_W = 11;
   localparam int ACC_W = 4;
   localparam int WORD_W = 16;
   localparam int OP_HI = 15;
   localparam int OP_LO = 11;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic DISP_RESET = 1'b0;
   // Five-bit major opcodes in word bits 15:11; target sits in bits 10:0
   localparam logic [4:0] OP_JUMP_IF_ACC_BIT2 = 5'h14;
   localparam logic [4:0] OP_JUMP_IF_ACC_BIT3 = 5'h16;
   localparam logic [4:0] OP_JUMP_IF_CARRY_SET = 5'h1d;
   localparam logic [4:0] OP_JUMP_IF_CARRY_CLEAR = 5'h1a;
   localparam logic [4:0] OP_JUMP_IF_NONZERO = 5'h18;
   localparam logic [4:0] OP_JUMP_IF_ZERO = 5'h1c;
   localparam logic [4:0] OP_ABSOLUTE_BRANCH = 5'h0e;
   // Full 16-bit display control words
   localparam logic [WORD_W-1:0] OP_DISPLAY_DRIVE_ON = 16'h0400;
   localparam logic [WORD_W-1:0] OP_DISPLAY_DRIVE_OFF = 16'h0500;

   typedef enum logic [3:0] {
      BDD_OP_NONE, BDD_OP_BIT2, BDD_OP_BIT3, BDD_OP_CSET, BDD_OP_CCLR,
      BDD_OP_NZ, BDD_OP_Z, BDD_OP_ABS, BDD_OP_DON, BDD_OP_DOFF
   } bdd_op_e;

   // Core state that the conditions test
   typedef struct packed {
      logic [ACC_W-1:0] work_accumulator;
      logic carry_flag;
   } bdd_cond_s;

   // Result of one decoded word
   typedef struct packed {
      bdd_op_e op;
      logic [PC_W-1:0] target;
   } bdd_dec_s;
endpackage : bdd_pkg
